// ---- core/arsp_core.sv ----
// Digital side of a continuously converting converter: saturation, filter-cycle timing,
// output word refresh and the three serial port modes, the asynchronous one at RES_W_BASE width only.
// Assumes all inputs are synchronous to ref_clk; host serial clock is sampled as a level.
`timescale 1ns/100ps

module arsp_core #(
    parameter int RES_W = arsp_pkg::RES_W_BASE
) (
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic [1:0]        port_mode,
    input  wire logic              bipolar,
    input  wire logic              filt_valid,
    input  wire logic signed [RES_W+1:0] filt_value,
    output logic                   filt_ready,
    input  wire logic              select_n,
    input  wire logic              host_sclk,
    input  wire logic              cal_start,
    input  wire logic              cal_type_sel_a,
    input  wire logic              cal_type_sel_b,
    output logic [1:0]             cal_type,
    output logic                   sample_tick,
    output logic                   result_ready_n,
    output logic                   serial_result_out,
    output logic                   serial_result_oe,
    output logic                   sclk_out,
    output logic                   sclk_oe
);
    localparam int CNT_W = $clog2(arsp_pkg::FILT_CYCLES);
    localparam int BIT_W = $clog2(RES_W);
    localparam int NBYTE = RES_W / arsp_pkg::BYTE_W;
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(arsp_pkg::FILT_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_RISE = CNT_W'(arsp_pkg::READY_HIGH);
    localparam logic [CNT_W-1:0] CNT_POLL = CNT_W'(arsp_pkg::POLL_FIRST - 1);
    localparam logic [CNT_W-1:0] POLL_MSK = CNT_W'(arsp_pkg::POLL_STEP - 1);
    localparam logic [CNT_W-1:0] SMP_MSK  = CNT_W'(arsp_pkg::SAMPLE_DIV - 1);
    localparam logic [1:0]       PH_LAST  = 2'(arsp_pkg::SCLK_DIV - 1);
    localparam logic [3:0]       CH_LAST  = 4'(arsp_pkg::CHAR_BITS - 1);

    typedef struct packed {
        logic [CNT_W-1:0]    cnt;
        logic                ready_n;
        logic [RES_W-1:0]    word;
        logic                fresh;
        arsp_pkg::arsp_xfer_t xs;
        logic [RES_W-1:0]    shift;
        logic [BIT_W-1:0]    bitn;
        logic [1:0]          phase;
        logic [10:0]         chr;
        logic [3:0]          chr_bit;
        logic [2:0]          bytes_left;
        logic                sdo;
        logic                sdo_oe;
        logic                sclk;
        logic                sclk_oe;
        logic                hsclk_q;
        logic                cal_q;
        logic [1:0]          cal_type;
        logic                smp;
    } arsp_core_st_t;

    arsp_core_st_t    q_reg;
    arsp_core_st_t    q_next;
    logic [RES_W-1:0] sat_word;
    logic             fifo_valid;
    logic [RES_W-1:0] fifo_data;
    logic             fifo_pop;
    logic             wrap;
    logic             poll;
    logic             hfall;
    logic             can_start;

    function automatic logic [RES_W-1:0] saturate(input logic signed [RES_W+1:0] v, input logic bip);
        logic signed [RES_W+2:0] t;
        t = bip ? ($signed({v[RES_W+1], v}) + $signed((RES_W+3)'(1) <<< (RES_W - 1))) : {v[RES_W+1], v};
        if (t < 0) begin
            saturate = '0;
        end else if (t > $signed({3'h0, {RES_W{1'b1}}})) begin
            saturate = '1;
        end else begin
            saturate = t[RES_W-1:0];
        end
    endfunction

    // Byte of the result word, most significant byte first
    function automatic logic [10:0] frame_byte(input logic [RES_W-1:0] w, input logic [2:0] idx);
        frame_byte = {2'h3, w[(idx * arsp_pkg::BYTE_W) +: arsp_pkg::BYTE_W], 1'b0};
    endfunction

    assign sat_word = saturate(filt_value, bipolar);

    // ------------------------------------------------------------
    // Result buffer
    // ------------------------------------------------------------
    arsp_fifo #(
        .W     (RES_W),
        .DEPTH (arsp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_valid  (filt_valid),
        .in_data   (sat_word),
        .in_ready  (filt_ready),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (fifo_pop)
    );

    // ------------------------------------------------------------
    // Cycle events
    // ------------------------------------------------------------
    assign wrap      = (q_reg.cnt == CNT_LAST);
    assign poll      = (q_reg.cnt >= CNT_POLL) && (((q_reg.cnt - CNT_POLL) & POLL_MSK) == '0);
    assign hfall     = q_reg.hsclk_q && !host_sclk;
    assign can_start = (q_reg.xs == arsp_pkg::XS_IDLE) && q_reg.fresh && !q_reg.ready_n && !select_n;
    assign fifo_pop  = wrap && (q_reg.xs == arsp_pkg::XS_IDLE) && fifo_valid;

    // Next-state logic for timing, word and transfer
    always_comb begin
        q_next         = q_reg;
        q_next.hsclk_q = host_sclk;
        q_next.cal_q   = cal_start;
        q_next.cnt = wrap ? '0 : q_reg.cnt + 1'b1;
        q_next.smp = ((q_next.cnt & SMP_MSK) == '0);
        if (q_next.cnt == CNT_RISE) begin
            q_next.ready_n = 1'b1;
        end
        if (fifo_pop) begin
            q_next.word    = fifo_data;
            q_next.fresh   = 1'b1;
            q_next.ready_n = 1'b0;
        end
        if (q_reg.cal_q && !cal_start) begin
            q_next.cal_type = {cal_type_sel_b, cal_type_sel_a};
        end
        case (q_reg.xs)
            arsp_pkg::XS_IDLE: begin
                if (port_mode == arsp_pkg::MODE_SELF && poll && can_start) begin
                    q_next.xs      = arsp_pkg::XS_SYNC;
                    q_next.sclk_oe = 1'b1;
                end else if (port_mode == arsp_pkg::MODE_HOST && can_start) begin
                    q_next.xs = arsp_pkg::XS_SYNC;
                end else if (port_mode == arsp_pkg::MODE_ASYNC && RES_W == arsp_pkg::RES_W_BASE && can_start) begin
                    q_next.xs         = arsp_pkg::XS_ASYNC;
                    q_next.chr        = frame_byte(q_reg.word, 3'(NBYTE - 1));
                    q_next.bytes_left = 3'(NBYTE - 1);
                end
                q_next.shift   = q_reg.word;
                q_next.bitn    = '0;
                q_next.phase   = '0;
                q_next.chr_bit = '0;
                q_next.sclk    = 1'b0;
                q_next.sdo     = (q_next.xs == arsp_pkg::XS_ASYNC) ? 1'b0 : q_reg.word[RES_W-1];
                q_next.sdo_oe  = (q_next.xs != arsp_pkg::XS_IDLE);
            end
            arsp_pkg::XS_SYNC: begin
                if (port_mode == arsp_pkg::MODE_SELF) begin
                    q_next.phase = q_reg.phase + 1'b1;
                    q_next.sclk  = (q_next.phase == PH_LAST);
                    if (q_reg.phase == PH_LAST) begin
                        if (q_reg.bitn == BIT_W'(RES_W - 1) || select_n) begin
                            q_next.xs      = arsp_pkg::XS_IDLE;
                            q_next.sdo_oe  = 1'b0;
                            q_next.sclk_oe = 1'b0;
                            q_next.sclk    = 1'b0;
                        end else begin
                            q_next.shift = {q_reg.shift[RES_W-2:0], 1'b0};
                            q_next.sdo   = q_reg.shift[RES_W-2];
                            q_next.bitn  = q_reg.bitn + 1'b1;
                        end
                        if (q_reg.bitn == BIT_W'(RES_W - 1)) begin
                            q_next.ready_n = 1'b1;
                            q_next.fresh   = 1'b0;
                        end
                    end
                end else if (select_n) begin
                    q_next.xs     = arsp_pkg::XS_IDLE;
                    q_next.sdo_oe = 1'b0;
                end else if (hfall) begin
                    if (q_reg.bitn == BIT_W'(RES_W - 1)) begin
                        q_next.xs      = arsp_pkg::XS_IDLE;
                        q_next.sdo_oe  = 1'b0;
                        q_next.ready_n = 1'b1;
                        q_next.fresh   = 1'b0;
                    end else begin
                        q_next.shift = {q_reg.shift[RES_W-2:0], 1'b0};
                        q_next.sdo   = q_reg.shift[RES_W-2];
                        q_next.bitn  = q_reg.bitn + 1'b1;
                    end
                end
            end
            arsp_pkg::XS_ASYNC: begin
                // character runs to second stop bit
                if (hfall) begin
                    if (q_reg.chr_bit != CH_LAST) begin
                        q_next.chr     = {1'b1, q_reg.chr[10:1]};
                        q_next.sdo     = q_reg.chr[1];
                        q_next.chr_bit = q_reg.chr_bit + 1'b1;
                    end else if (q_reg.bytes_left != '0 && !select_n) begin
                        q_next.chr        = frame_byte(q_reg.word, q_reg.bytes_left - 1'b1);
                        q_next.sdo        = 1'b0;
                        q_next.chr_bit    = '0;
                        q_next.bytes_left = q_reg.bytes_left - 1'b1;
                    end else begin
                        q_next.xs     = arsp_pkg::XS_IDLE;
                        q_next.sdo_oe = 1'b0;
                        if (q_reg.bytes_left == '0) begin
                            q_next.ready_n = 1'b1;
                            q_next.fresh   = 1'b0;
                        end
                    end
                end
            end
            default: begin
                q_next.xs     = arsp_pkg::XS_IDLE;
                q_next.sdo_oe = 1'b0;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_reg         <= '0;
            q_reg.ready_n <= 1'b1;
            q_reg.xs      <= arsp_pkg::XS_IDLE;
        end else begin
            q_reg <= q_next;
        end
    end

    // Outputs straight from the state register
    assign cal_type          = q_reg.cal_type;
    assign sample_tick       = q_reg.smp;
    assign result_ready_n    = q_reg.ready_n;
    assign serial_result_out = q_reg.sdo;
    assign serial_result_oe  = q_reg.sdo_oe;
    assign sclk_out          = q_reg.sclk;
    assign sclk_oe           = q_reg.sclk_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_bit_high;
        sclk_out ##1 !sclk_out [*3];
    endsequence

    chk_sat_high: assert property (filt_value > $signed({2'h0, {RES_W{1'b1}}}) && !bipolar |-> sat_word == '1)
        else $error("Over-range value not saturated to all ones");
    chk_sat_low: assert property (filt_value < 0 && !bipolar |-> sat_word == '0)
        else $error("Under-range value not saturated to zero");
    chk_ready_rise: assert property (q_reg.cnt == CNT_RISE - 1'b1 |=> result_ready_n)
        else $error("Result ready not high at cycle 1020");
    chk_ready_wrap: assert property (fifo_pop |=> !result_ready_n && q_reg.cnt == '0)
        else $error("Result ready did not fall at filter cycle start");
    chk_no_refresh: assert property (wrap && q_reg.xs != arsp_pkg::XS_IDLE |=> $stable(q_reg.word))
        else $error("Output word refreshed during transfer");
    chk_self_poll: assert property (port_mode == arsp_pkg::MODE_SELF && can_start && !poll |=> q_reg.xs == arsp_pkg::XS_IDLE)
        else $error("Self-clocked transfer started outside a poll");
    chk_sclk_quarter: assert property ($rose(sclk_out) |-> s_bit_high)
        else $error("Serial clock not one high in four");
    chk_self_release: assert property (port_mode == arsp_pkg::MODE_SELF && q_reg.xs == arsp_pkg::XS_SYNC && select_n |-> ##[1:4] !serial_result_oe && !sclk_oe)
        else $error("Outputs not floated after select release");
    chk_host_ignore: assert property (port_mode == arsp_pkg::MODE_HOST && q_reg.xs == arsp_pkg::XS_IDLE && result_ready_n |=> q_reg.xs == arsp_pkg::XS_IDLE)
        else $error("Select honoured while result ready high");
    chk_host_shift: assert property (port_mode == arsp_pkg::MODE_HOST && q_reg.xs == arsp_pkg::XS_SYNC && !select_n && hfall && q_reg.bitn != BIT_W'(RES_W - 1) |=> serial_result_out == $past(q_reg.shift[RES_W-2]))
        else $error("Data did not advance on host clock fall");
    chk_async_hold: assert property (q_reg.xs == arsp_pkg::XS_ASYNC && q_reg.chr_bit != CH_LAST |=> serial_result_oe)
        else $error("Character cut short");
    chk_idle_float: assert property (q_reg.xs == arsp_pkg::XS_IDLE |-> !serial_result_oe && !sclk_oe)
        else $error("Outputs driven while idle");
    chk_cal_capture: assert property ($fell(cal_start) |=> cal_type == $past({cal_type_sel_b, cal_type_sel_a}))
        else $error("Calibration type not captured");

endmodule

// ---- core/arsp_pkg.sv ----
// Constants, state encodings and timing counts of the converter result serial port.
// Assumes one master clock (ref_clk, 25 MHz) drives all logic; no bus, plain ports only.

package arsp_pkg;

    // ------------------------------------------------------------
    // Word widths and port modes
    // ------------------------------------------------------------
    localparam int         RES_W_BASE  = 16;
    localparam int         RES_W_HIRES = 20;
    localparam int         BYTE_W      = 8;
    localparam logic [1:0] MODE_SELF   = 2'h0;   // Mode pin high
    localparam logic [1:0] MODE_HOST   = 2'h1;   // Mode pin at ground
    localparam logic [1:0] MODE_ASYNC  = 2'h2;   // Mode pin at negative supply

    // ------------------------------------------------------------
    // Timing counts in master clock cycles, plus character bits, buffer depth and nanosecond times
    // ------------------------------------------------------------
    localparam int FILT_CYCLES  = 1024;
    localparam int READY_HIGH   = 1020;
    localparam int POLL_FIRST   = 76;
    localparam int POLL_STEP    = 128;
    localparam int SAMPLE_DIV   = 256;
    localparam int SCLK_DIV     = 4;
    localparam int CHAR_BITS    = 11;
    localparam int FIFO_DEPTH   = 16;
    localparam int CLK_PERIOD_NS   = 40;
    localparam int HOST_WAIT_NS    = 160;
    localparam int HOST_WAIT_CYC   = 4 + (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Transfer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {XS_IDLE, XS_SYNC, XS_ASYNC} arsp_xfer_t;

endpackage

// ---- core/arsp_fifo.sv ----
// Result FIFO between the filter output and the serial output word.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps

module arsp_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wr;
        logic [AW-1:0]           rd;
        logic [CW-1:0]           cnt;
        logic                    full;
    } arsp_fifo_st_t;

    arsp_fifo_st_t q_reg;
    arsp_fifo_st_t q_next;
    logic          push;
    logic          pop;

    // ------------------------------------------------------------
    // Handshake and storage update
    // ------------------------------------------------------------
    assign in_ready  = !q_reg.full;
    assign out_valid = (q_reg.cnt != '0);
    assign out_data  = q_reg.mem[q_reg.rd];
    assign push      = in_valid && !q_reg.full;
    assign pop       = out_ready && out_valid;

    // Pointer and count bookkeeping
    always_comb begin
        q_next = q_reg;
        if (push) begin
            q_next.mem[q_reg.wr] = in_data;
            q_next.wr = (q_reg.wr == AW'(DEPTH - 1)) ? '0 : q_reg.wr + 1'b1;
        end
        if (pop) begin
            q_next.rd = (q_reg.rd == AW'(DEPTH - 1)) ? '0 : q_reg.rd + 1'b1;
        end
        if (push && !pop) begin
            q_next.cnt = q_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            q_next.cnt = q_reg.cnt - 1'b1;
        end
        q_next.full = (q_next.cnt == CW'(DEPTH));
    end

    // State register
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            q_reg <= '0;
        end else begin
            q_reg <= q_next;
        end
    end

endmodule

// ---- testbench/arsp_host_model.sv ----
// Host side model: drives select and the host serial clock, collects serial bits.
// Assumes the core samples all inputs on ref_clk rising edges.
`timescale 1ns/100ps

module arsp_host_model (
    input  wire logic ref_clk,
    output logic      select_n,
    output logic      host_sclk,
    input  wire logic sdo,
    input  wire logic sdo_oe,
    input  wire logic sclk_out
);
    initial begin
        select_n  = 1'b1;
        host_sclk = 1'b0;
    end

    // Let n edges pass, then move off the edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // Read n bits; a released line reads as unknown so stale data never matches
    task automatic read_bits(input int n, input bit selfclk, input int low_cyc, input int rel,
                             output logic [21:0] bits);
        int i;
        int t;
        bits = 22'h0;
        select_n = 1'b0;
        step(arsp_pkg::HOST_WAIT_CYC);
        for (i = 0; i < n; i++) begin
            if (i == rel) select_n = 1'b1;
            t = 0;
            if (selfclk) begin
                while (sclk_out !== 1'b1 && t < 200) begin
                    step(1);
                    t++;
                end
                bits = {bits[20:0], sdo_oe ? sdo : 1'bx};
                while (sclk_out === 1'b1 && t < 200) begin
                    step(1);
                    t++;
                end
            end else begin
                bits = {bits[20:0], sdo_oe ? sdo : 1'bx};
                host_sclk = 1'b1;
                step(2);
                host_sclk = 1'b0;
                step(low_cyc);
            end
        end
        select_n = 1'b1;
    endtask
endmodule

// ---- testbench/adc_result_serial_port_test.sv ----
// Self-checking bench for the converter result serial port core.
// Assumes the host model beside it and one 25 MHz clock.
`timescale 1ns/100ps

module adc_result_serial_port_test;
    typedef struct packed {
        logic [1:0]         mode;
        logic               bip;
        logic signed [17:0] val;
        logic [15:0]        word;
    } arsp_row_t;

    logic               ref_clk, srst, bipolar, filt_valid, filt_ready, cal_start, sel_a, sel_b;
    logic               sample_tick, result_ready_n, sdo, sdo_oe, sclk_out, sclk_oe, select_n, host_sclk;
    logic [1:0]         port_mode, cal_type;
    logic signed [17:0] filt_value;
    logic [21:0]        got;
    int                 n_fail = 0, n_compared = 0, cycles = 0, t, k;
    arsp_row_t          rows [9] = '{
        '{arsp_pkg::MODE_HOST, 1'b0, 18'h01234, 16'h1234}, '{arsp_pkg::MODE_HOST, 1'b0, 18'h1ffff, 16'hffff},
        '{arsp_pkg::MODE_HOST, 1'b0, 18'h3fffb, 16'h0000}, '{arsp_pkg::MODE_HOST, 1'b1, 18'h00000, 16'h8000},
        '{arsp_pkg::MODE_HOST, 1'b1, 18'h363c0, 16'h0000}, '{arsp_pkg::MODE_SELF, 1'b1, 18'h09c40, 16'hffff},
        '{arsp_pkg::MODE_SELF, 1'b0, 18'h0a5c3, 16'ha5c3}, '{arsp_pkg::MODE_ASYNC, 1'b0, 18'h05a3c, 16'h5a3c},
        '{arsp_pkg::MODE_ASYNC, 1'b1, 18'h3ffff, 16'h7fff}};

    arsp_core #(.RES_W(16)) u_dut (
        .ref_clk(ref_clk), .srst(srst), .port_mode(port_mode), .bipolar(bipolar),
        .filt_valid(filt_valid), .filt_value(filt_value), .filt_ready(filt_ready),
        .select_n(select_n), .host_sclk(host_sclk), .cal_start(cal_start),
        .cal_type_sel_a(sel_a), .cal_type_sel_b(sel_b), .cal_type(cal_type),
        .sample_tick(sample_tick), .result_ready_n(result_ready_n), .serial_result_out(sdo),
        .serial_result_oe(sdo_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe));

    arsp_host_model u_host (
        .ref_clk(ref_clk), .select_n(select_n), .host_sclk(host_sclk),
        .sdo(sdo), .sdo_oe(sdo_oe), .sclk_out(sclk_out));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    // clock never stops
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Cut a hang short
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            $display("[FAIL] %0t run took too long", $time);
            end_of_test();
        end
    end

    task automatic cmp_word(input logic [21:0] g, input logic [21:0] e, input string what);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask

    task automatic cmp_flag(input logic g, input logic e, input string what);
        cmp_word({21'h0, g}, {21'h0, e}, what);
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic push(input logic signed [17:0] v);
        filt_value = v;
        filt_valid = 1'b1;
        step(1);
        filt_valid = 1'b0;
        // Let an edge pass so a following push never lowers and raises valid at once
        step(1);
    endtask

    // Wait for a fresh fall of the ready line
    task automatic wait_new();
        t = 0;
        while (result_ready_n !== 1'b1 && t < 3000) begin
            step(1);
            t++;
        end
        while (result_ready_n !== 1'b0 && t < 3000) begin
            step(1);
            t++;
        end
        cmp_flag(t < 3000, 1'b1, "no new word");
    endtask

    // Expected async stream: two chars, start bit, LSB first, two stop bits
    function automatic logic [21:0] async_exp(input logic [15:0] w);
        logic [21:0] s;
        s = 22'h001803;
        for (int i = 0; i < 8; i++) begin
            s[20-i] = w[8+i];
            s[9-i]  = w[i];
        end
        return s;
    endfunction

    task automatic end_of_test();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        srst = 1'b1; port_mode = arsp_pkg::MODE_HOST; bipolar = 1'b0; filt_valid = 1'b0;
        filt_value = 18'h0; cal_start = 1'b0; sel_a = 1'b0; sel_b = 1'b0;
        step(2);
        srst = 1'b0;
        cmp_flag(result_ready_n, 1'b1, "ready after reset");
        cmp_flag(sdo_oe | sclk_oe, 1'b0, "float after reset");
        foreach (rows[r]) begin
            port_mode = rows[r].mode;
            bipolar = rows[r].bip;
            push(rows[r].val);
            wait_new();
            if (rows[r].mode == arsp_pkg::MODE_ASYNC) begin
                u_host.read_bits(22, 1'b0, 3, 99, got);
                cmp_word(got, async_exp(rows[r].word), "async chars");
            end else begin
                u_host.read_bits(16, rows[r].mode == arsp_pkg::MODE_SELF, 3, 99, got);
                cmp_word(got, {6'h0, rows[r].word}, "word");
            end
            step(2);
            cmp_flag(sdo_oe | sclk_oe, 1'b0, "float when idle");
        end
        // select ignored while ready high
        // Unread word with ready raised at cycle 1020 and an empty buffer: only the ready gate refuses
        port_mode = arsp_pkg::MODE_HOST;
        push(18'h00333);
        wait_new();
        while (result_ready_n !== 1'b1) step(1);
        u_host.read_bits(2, 1'b0, 3, 99, got);
        cmp_word(got[1:0], 2'bxx, "start while ready high");
        // ready low 1020 then high 4
        bipolar = 1'b0;
        push(18'h00111);
        push(18'h00222);
        wait_new();
        for (t = 0; result_ready_n === 1'b0 && t < 1100; t++) step(1);
        cmp_word(22'(t), 22'h3fc, "ready low length");
        for (t = 0; result_ready_n === 1'b1 && t < 10; t++) step(1);
        cmp_word(22'(t), 22'h4, "ready high length");
        u_host.read_bits(16, 1'b0, 3, 99, got);
        cmp_word(got, 22'h000222, "refreshed word");
        // slow read across the wrap keeps the word
        push(18'h0abcd);
        push(18'h04321);
        wait_new();
        u_host.read_bits(16, 1'b0, 70, 99, got);
        cmp_word(got, 22'h00abcd, "slow word");
        wait_new();
        u_host.read_bits(16, 1'b0, 3, 99, got);
        cmp_word(got, 22'h004321, "next word");
        for (t = 0; sample_tick !== 1'b1 && t < 300; t++) step(1);
        step(1);
        for (t = 1; sample_tick !== 1'b1 && t < 300; t++) step(1);
        cmp_word(22'(t), 22'h100, "sample period");
        port_mode = arsp_pkg::MODE_SELF;
        push(18'h0c3a5);
        wait_new();
        u_host.read_bits(6, 1'b1, 3, 5, got);
        cmp_word(got[5:0], 6'h30, "self partial bits");
        step(1);
        cmp_flag(sdo_oe | sclk_oe, 1'b0, "self float");
        port_mode = arsp_pkg::MODE_ASYNC;
        push(18'h096e1);
        wait_new();
        u_host.read_bits(11, 1'b0, 3, 3, got);
        cmp_word(got[10:0], async_exp(16'h96e1) >> 11, "async tail");
        cmp_flag(sdo_oe, 1'b0, "async float");
        // Fill the buffer until it refuses, then drain it
        port_mode = arsp_pkg::MODE_HOST;
        filt_valid = 1'b1;
        for (k = 0; k < 17; k++) begin
            filt_value = 18'h01000 + 18'(k);
            cmp_flag(filt_ready, k < 16, "buffer space");
            step(1);
        end
        filt_valid = 1'b0;
        for (k = 0; k < 16; k++) begin
            wait_new();
            u_host.read_bits(16, 1'b0, 3, 99, got);
            cmp_word(got, 22'h001000 + 22'(k), "drained word");
        end
        step(1100);
        cmp_flag(result_ready_n, 1'b1, "buffer empty");
        for (k = 0; k < 4; k++) begin
            sel_a = k[0];
            sel_b = k[1];
            cal_start = 1'b1;
            step(2);
            cal_start = 1'b0;
            step(3);
            cmp_word({20'h0, cal_type}, 22'(k), "cal type");
        end
        end_of_test();
    end
endmodule
